// ### bench/dcsr_host.sv
// Host model that issues register writes and reads on the access port.
`timescale 1ns/100ps
module dcsr_host (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rd_valid,
  input  wire logic        cmd_refused,
  output logic             wr_en,
  output logic             rd_en,
  output logic [4:0]       addr,
  output logic [15:0]      wdata
);
  // Idle strobes from time zero.
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 5'h00;
    wdata = 16'h0000;
  end

  // Write one word; the refusal pulse is sampled one cycle later.
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    output logic refused);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en   = 1'b0;
    refused = cmd_refused;
    addr    = ~a;  // Released lines no longer show the last value.
    wdata   = ~d;
  endtask

  // Read one word; ok stays low if neither answer nor refusal came.
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic refused, output logic ok);
    int i;
    @(negedge clk);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en   = 1'b0;
    addr    = ~a;
    ok      = 1'b0;
    refused = 1'b0;
    d       = 16'h0000;
    for (i = 0; i < 4 && !ok; i++) begin
      if (rd_valid === 1'b1 || cmd_refused === 1'b1) begin
        ok      = 1'b1;
        d       = rdata;
        refused = cmd_refused;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule // dcsr_host

// ### bench/test_dac_config_status_regs.sv
// Self-checking testbench for the converter configuration registers.
`timescale 1ns/100ps
module test_dac_config_status_regs;
  import dcsr_pkg::*;
  logic        clk, nrst, wr_en, rd_en, hv, cmd_refused, bandgap_on;
  logic        rd_valid, nv_access_active, refd, ok, nv_vol;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, rv, lock_init, ref_init, rdata_vol;
  logic [3:0]  reference_select_bits, power_down_bits;
  logic [1:0]  gain_eff, ref_buffer_on, ref_pin_driven, c;
  logic [1:0]  pd_1k, pd_100k, pd_open;
  logic [23:0] dac_value;
  logic [11:0] keep;
  int          n_mismatch, checks, i;

`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end

  ////////////////////////////////////////
  // Clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dcsr_regs u_dut (.clk(clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .high_voltage_program_pin(hv),
    .nv_ref_init(ref_init), .nv_pd_init(16'h0000),
    .nv_gain_init(16'h0000), .nv_lock_init(lock_init), .rdata(rdata),
    .rd_valid(rd_valid), .cmd_refused(cmd_refused),
    .nv_access_active(nv_access_active),
    .reference_select_bits(reference_select_bits),
    .power_down_bits(power_down_bits), .gain_eff(gain_eff),
    .ref_buffer_on(ref_buffer_on), .bandgap_on(bandgap_on),
    .ref_pin_driven(ref_pin_driven), .pd_1k(pd_1k), .pd_100k(pd_100k),
    .pd_open(pd_open), .dac_value(dac_value));

  // Volatile-only build on the same bus, watched for its access bit.
  dcsr_regs #(.HAS_NV(1'b0)) u_dut_vol (.clk(clk), .nrst(nrst),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .high_voltage_program_pin(hv), .nv_ref_init(ref_init),
    .nv_pd_init(16'h0000), .nv_gain_init(16'h0000),
    .nv_lock_init(lock_init), .rdata(rdata_vol), .rd_valid(),
    .cmd_refused(), .nv_access_active(nv_vol),
    .reference_select_bits(), .power_down_bits(), .gain_eff(),
    .ref_buffer_on(), .bandgap_on(), .ref_pin_driven(), .pd_1k(),
    .pd_100k(), .pd_open(), .dac_value());

  dcsr_host u_host (.clk(clk), .rdata(rdata), .rd_valid(rd_valid),
    .cmd_refused(cmd_refused), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));

  ////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic w(input logic [4:0] a, input logic [15:0] d);
    u_host.wr(a, d, refd);
  endtask

  // A read with no answer in time ends the run as a failure.
  task automatic r(input logic [4:0] a);
    u_host.rd(a, rv, refd, ok);
    if (!ok) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Decode outputs follow a write by two cycles.
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 40 && nv_access_active !== 1'b0; k++) begin
      @(negedge clk);
    end
    if (nv_access_active !== 1'b0) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Power event: four cycles low, then stop just after the boot edge.
  task automatic do_reset();
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  ////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    checks     = 0;
    nrst       = 1'b0;
    hv         = 1'b0;
    lock_init  = 16'h0000;
    ref_init   = 16'h0000;
    do_reset();
    `CHK("boot busy", 1'b1, nv_access_active)
    `CHK("vol never busy", 1'b0, nv_vol)
    r(ADDR_REF_NV);
    `CHK("nv read busy", 1'b1, refd)
    wait_idle();
    r(ADDR_GAIN_ST);
    `CHK("status first", STATUS_RESET, rv)
    r(ADDR_GAIN_ST);
    `CHK("status again", ZERO16, rv)
    r(ADDR_REF_V);
    `CHK("ref reset", ZERO16, rv)
    r(ADDR_PD_V);
    `CHK("pd reset", ZERO16, rv)
    r(5'h05);
    `CHK("unmapped", ZERO16, rv)
    w(ADDR_REF_NV, 16'h0005);
    `CHK("nv write no hv", 1'b1, refd)
    hv = 1'b1;
    repeat (5) @(negedge clk);
    w(ADDR_GAIN_NV, 16'h0300);
    `CHK("nv write hv", 1'b0, refd)
    @(negedge clk);
    `CHK("write busy", 1'b1, nv_access_active)
    w(ADDR_REF_V, 16'h0005);
    `CHK("vol write busy", 1'b0, refd)
    r(ADDR_GAIN_ST);
    `CHK("status busy", 16'h0040, rv)
    `CHK("vol status", ZERO16, rdata_vol)
    r(ADDR_GAIN_NV);
    `CHK("nv read busy", 1'b1, refd)
    wait_idle();
    hv = 1'b0;
    r(ADDR_GAIN_NV);
    `CHK("nv gain", 16'h0300, rv)
    // Every reference code with both gains asking for double.
    w(ADDR_GAIN_ST, 16'h0300);
    for (i = 0; i < 4; i++) begin
      c = i[1:0];
      w(ADDR_REF_V, {12'h000, c, c});
      settle();
      `CHK("ref bits", {c, c}, reference_select_bits)
      `CHK("buffer", {2{c[0]}}, ref_buffer_on)
      `CHK("band gap", c == REF_BANDGAP, bandgap_on)
      `CHK("gain", (c == REF_SUPPLY) ? 2'b00 : 2'b11, gain_eff)
    end
    // Every power-down code while the band gap drives the pin.
    w(ADDR_REF_V, 16'h0005);
    for (i = 0; i < 4; i++) begin
      c = i[1:0];
      w(ADDR_PD_V, {12'h000, c, c});
      settle();
      `CHK("pd 1k", {2{c == PD_1K}}, pd_1k)
      `CHK("pd 100k", {2{c == PD_100K}}, pd_100k)
      `CHK("pd open", {2{c == PD_OPEN}}, pd_open)
      `CHK("pin driven", 2'b11, ref_pin_driven)
    end
    w(ADDR_REF_V, 16'h0000);
    settle();
    `CHK("band gap off", 1'b0, bandgap_on)
    w(ADDR_REF_V, 16'hffff);
    r(ADDR_REF_V);
    `CHK("ref unimpl", 16'h000f, rv)
    w(ADDR_PD_V, 16'hffff);
    r(ADDR_PD_V);
    `CHK("pd unimpl", 16'h000f, rv)
    r(ADDR_LOCK_NV);
    `CHK("lock reset", ZERO16, rv)
    r(ADDR_PD_NV);
    `CHK("pd nv reset", ZERO16, rv)
    // Second power event: config lock on ch0, value lock on ch1.
    lock_init = 16'h0009;
    ref_init  = 16'h0006;
    do_reset();
    wait_idle();
    `CHK("ref loaded", 4'h6, reference_select_bits)
    r(ADDR_DAC1);
    keep = rv[11:0];
    w(ADDR_REF_V, 16'h0000);
    w(ADDR_PD_V, 16'h000f);
    w(ADDR_DAC0, 16'h0abc);
    w(ADDR_DAC1, 16'h0123);
    settle();
    `CHK("ref locked", 4'h2, reference_select_bits)
    `CHK("pd free", 4'hf, power_down_bits)
    `CHK("dac0 free", 12'habc, dac_value[11:0])
    `CHK("dac1 locked", keep, dac_value[23:12])
    hv = 1'b1;
    repeat (5) @(negedge clk);
    w(ADDR_LOCK_NV, 16'h0000);
    `CHK("nv under lock", 1'b0, refd)
    hv = 1'b0;
    wait_idle();
    r(ADDR_LOCK_NV);
    `CHK("nv lock written", ZERO16, rv)
    tally_and_finish();
  end
endmodule // test_dac_config_status_regs

// ### hdl/dcsr_pkg.sv
// Constants for the converter configuration and status registers.
// How it works
// - Reference code 11 external buffered, 10 external unbuffered, 00 supply.
// - Code 01 selects band gap, buffered; it keeps driving reference pin.
// - Codes 00, 10 and 11 switch the band gap off once no channel holds 01.
// - Power-down register holds two bits per channel in the low bits.
// - Power-down 00 normal, 01 1k pull-down, 10 100k, 11 open.
// - Gain bits sit at bit 8 and bit 9; one means double gain.
// - Reference code 00 forces unity gain whatever the gain bit holds.
// - Status bit 7 sets on power event and clears on status read.
// - Bit 6 shows nonvolatile access; only volatile commands accepted then.
// - Volatile-only builds read the access bit as zero.
// - Nonvolatile gain register at 1Ah holds one gain bit per channel.
// - Lock 11 locks value and config, 10 value, 01 config, 00 none.
// - Locks gate volatile writes only; nonvolatile writes need high voltage.
// - Volatile power-down bits stay writable under a configuration lock.
// - Unimplemented bits of reference, power-down, lock registers read zero.
// - Power event loads volatile reference bits from nonvolatile copy.
// - After power-up load status reads 0080h with nonvolatile gain bits; reference and power-down read nonvolatile copies.
package dcsr_pkg;
  localparam logic [4:0]  ADDR_DAC0     = 5'h00;
  localparam logic [4:0]  ADDR_DAC1     = 5'h01;
  localparam logic [4:0]  ADDR_REF_V    = 5'h08;
  localparam logic [4:0]  ADDR_PD_V     = 5'h09;
  localparam logic [4:0]  ADDR_GAIN_ST  = 5'h0a;
  localparam logic [4:0]  ADDR_NV_DAC0  = 5'h10;
  localparam logic [4:0]  ADDR_NV_DAC1  = 5'h11;
  localparam logic [4:0]  ADDR_REF_NV   = 5'h18;
  localparam logic [4:0]  ADDR_PD_NV    = 5'h19;
  localparam logic [4:0]  ADDR_GAIN_NV  = 5'h1a;
  localparam logic [4:0]  ADDR_LOCK_NV  = 5'h1b;
  localparam logic [4:0]  NV_ADDR_BIT   = 5'h04;
  localparam int          GAIN_LSB      = 8;
  localparam int          POR_BIT       = 7;
  localparam int          NVA_BIT       = 6;
  localparam logic [15:0] STATUS_RESET  = 16'h0080;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [1:0]  REF_SUPPLY    = 2'h0;
  localparam logic [1:0]  REF_BANDGAP   = 2'h1;
  localparam logic [1:0]  REF_EXT_UNBUF = 2'h2;
  localparam logic [1:0]  REF_EXT_BUF   = 2'h3;
  localparam logic [1:0]  PD_NORMAL     = 2'h0;
  localparam logic [1:0]  PD_1K         = 2'h1;
  localparam logic [1:0]  PD_100K       = 2'h2;
  localparam logic [1:0]  PD_OPEN       = 2'h3;
  localparam int          LOCK_CFG_BIT  = 0;
  localparam int          LOCK_VAL_BIT  = 1;
  localparam int          NV_LOAD_CYC   = 4;
  localparam int          NV_WRITE_CYC  = 16;
endpackage : dcsr_pkg

// ### hdl/dcsr_regs.sv
// Configuration and status registers of a one- or two-channel converter.
`timescale 1ns/100ps
module dcsr_regs
  import dcsr_pkg::*;
#(
  parameter int   CHANNELS = 2,
  parameter bit   HAS_NV   = 1'b1,
  parameter int   VAL_W    = 12
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  input  wire logic [4:0]            addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  high_voltage_program_pin,
  input  wire logic [15:0]           nv_ref_init,
  input  wire logic [15:0]           nv_pd_init,
  input  wire logic [15:0]           nv_gain_init,
  input  wire logic [15:0]           nv_lock_init,
  output logic [15:0]                rdata,
  output logic                       rd_valid,
  output logic                       cmd_refused,
  output logic                       nv_access_active,
  output logic [2*CHANNELS-1:0]      reference_select_bits,
  output logic [2*CHANNELS-1:0]      power_down_bits,
  output logic [CHANNELS-1:0]        gain_eff,
  output logic [CHANNELS-1:0]        ref_buffer_on,
  output logic                       bandgap_on,
  output logic [CHANNELS-1:0]        ref_pin_driven,
  output logic [CHANNELS-1:0]        pd_1k,
  output logic [CHANNELS-1:0]        pd_100k,
  output logic [CHANNELS-1:0]        pd_open,
  output logic [CHANNELS*VAL_W-1:0]  dac_value
);
  localparam int FW = 2 * CHANNELS;

  typedef struct packed {
    logic [FW-1:0]           ref_v;
    logic [FW-1:0]           pd_v;
    logic [CHANNELS-1:0]     gain_v;
    logic                    por_flag;
    logic [FW-1:0]           ref_nv;
    logic [FW-1:0]           pd_nv;
    logic [CHANNELS-1:0]     gain_nv;
    logic [FW-1:0]           lock_nv;
    logic [CHANNELS*VAL_W-1:0] val;
    logic [4:0]              nv_cnt;
    logic                    nv_busy;
    logic                    boot;
    logic [15:0]             rdata;
    logic                    rd_valid;
    logic                    refused;
    logic [FW-1:0]           ref_o;
    logic [FW-1:0]           pd_o;
    logic [CHANNELS-1:0]     gain_o;
    logic [CHANNELS-1:0]     buf_o;
    logic                    bg_o;
    logic [CHANNELS-1:0]     drv_o;
    logic [CHANNELS-1:0]     p1k_o;
    logic [CHANNELS-1:0]     p100k_o;
    logic [CHANNELS-1:0]     popen_o;
  } dcsr_regs_s;

  dcsr_regs_s st_q;
  dcsr_regs_s st_d;
  logic       hv_level;

  // Widen a field into a 16-bit word with the upper bits zero.
  function automatic logic [15:0] zext(input logic [FW-1:0] f);
    logic [15:0] w;
    w = ZERO16;
    w[FW-1:0] = f;
    return w;
  endfunction

  // Locked configuration of one channel from its lock field.
  function automatic logic cfg_locked(input logic [FW-1:0] lk, input int ch);
    return lk[2*ch+LOCK_CFG_BIT];
  endfunction

  // The programming pin comes from outside and is synchronised.
  dcsr_sync u_hv_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (high_voltage_program_pin),
    .level (hv_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: register writes, reads, power-up load, decode.
  always_comb begin
    logic nv_addr;
    logic [1:0] r;
    st_d          = st_q;
    nv_addr       = 1'b0;
    r             = 2'h0;
    st_d.rd_valid = 1'b0;
    st_d.refused  = 1'b0;
    nv_addr       = addr[4] & (addr >= ADDR_NV_DAC0);
    // Power-up copies the nonvolatile copy into the volatile registers.
    if (st_q.boot) begin
      st_d.boot    = 1'b0;
      st_d.nv_busy = HAS_NV;
      st_d.nv_cnt  = 5'(NV_LOAD_CYC);
      if (HAS_NV) begin
        st_d.ref_nv  = nv_ref_init[FW-1:0];
        st_d.pd_nv   = nv_pd_init[FW-1:0];
        st_d.gain_nv = nv_gain_init[CHANNELS-1:0];
        st_d.lock_nv = nv_lock_init[FW-1:0];
        st_d.ref_v   = nv_ref_init[FW-1:0];
        st_d.pd_v    = nv_pd_init[FW-1:0];
        st_d.gain_v  = nv_gain_init[CHANNELS-1:0];
      end
    end else if (st_q.nv_busy) begin
      if (st_q.nv_cnt <= 5'h01) begin
        st_d.nv_busy = 1'b0;
        st_d.nv_cnt  = 5'h00;
      end else begin
        st_d.nv_cnt = st_q.nv_cnt - 5'h01;
      end
    end
    // Writes.
    if (wr_en && !st_q.boot) begin
      if (nv_addr && (st_q.nv_busy || !hv_level || !HAS_NV)) begin
        st_d.refused = 1'b1;
      end else if (nv_addr) begin
        st_d.nv_busy = 1'b1;
        st_d.nv_cnt  = 5'(NV_WRITE_CYC);
        case (addr)
          ADDR_REF_NV:  st_d.ref_nv  = wdata[FW-1:0];
          ADDR_PD_NV:   st_d.pd_nv   = wdata[FW-1:0];
          ADDR_GAIN_NV: st_d.gain_nv = wdata[GAIN_LSB +: CHANNELS];
          ADDR_LOCK_NV: st_d.lock_nv = wdata[FW-1:0];
          default:      st_d.refused = 1'b0;
        endcase
      end else begin
        case (addr)
          ADDR_REF_V: begin
            for (int c = 0; c < CHANNELS; c++) begin
              if (!cfg_locked(st_q.lock_nv, c)) begin
                st_d.ref_v[2*c +: 2] = wdata[2*c +: 2];
              end
            end
          end
          ADDR_PD_V: st_d.pd_v = wdata[FW-1:0];
          ADDR_GAIN_ST: begin
            for (int c = 0; c < CHANNELS; c++) begin
              if (!cfg_locked(st_q.lock_nv, c)) begin
                st_d.gain_v[c] = wdata[GAIN_LSB+c];
              end
            end
          end
          default: begin
            for (int c = 0; c < CHANNELS; c++) begin
              if (addr == 5'(c) && !st_q.lock_nv[2*c+LOCK_VAL_BIT]) begin
                st_d.val[c*VAL_W +: VAL_W] = wdata[VAL_W-1:0];
              end
            end
          end
        endcase
      end
    end
    // Reads; the status read clears the power event flag.
    if (rd_en && !st_q.boot) begin
      st_d.rd_valid = 1'b1;
      st_d.rdata    = ZERO16;
      if (nv_addr && st_q.nv_busy) begin
        st_d.refused  = 1'b1;
      end else begin
        case (addr)
          ADDR_REF_V:  st_d.rdata = zext(st_q.ref_v);
          ADDR_PD_V:   st_d.rdata = zext(st_q.pd_v);
          ADDR_GAIN_ST: begin
            st_d.rdata[GAIN_LSB +: CHANNELS] = st_q.gain_v;
            st_d.rdata[POR_BIT] = st_q.por_flag;
            st_d.rdata[NVA_BIT] = st_q.nv_busy & HAS_NV;
            st_d.por_flag = 1'b0;
          end
          ADDR_REF_NV:  st_d.rdata = HAS_NV ? zext(st_q.ref_nv) : ZERO16;
          ADDR_PD_NV:   st_d.rdata = HAS_NV ? zext(st_q.pd_nv) : ZERO16;
          ADDR_LOCK_NV: st_d.rdata = HAS_NV ? zext(st_q.lock_nv) : ZERO16;
          ADDR_GAIN_NV: begin
            if (HAS_NV) begin
              st_d.rdata[GAIN_LSB +: CHANNELS] = st_q.gain_nv;
            end
          end
          default: begin
            for (int c = 0; c < CHANNELS; c++) begin
              if (addr == 5'(c)) begin
                st_d.rdata[VAL_W-1:0] = st_q.val[c*VAL_W +: VAL_W];
              end
            end
          end
        endcase
      end
    end
    // Per-channel decode of reference, gain and power-down.
    st_d.bg_o = 1'b0;
    for (int c = 0; c < CHANNELS; c++) begin
      r = st_q.ref_v[2*c +: 2];
      st_d.buf_o[c]  = (r == REF_EXT_BUF) || (r == REF_BANDGAP);
      st_d.drv_o[c]  = (r == REF_BANDGAP);
      if (r == REF_BANDGAP) begin
        st_d.bg_o = 1'b1;
      end
      st_d.gain_o[c] = st_q.gain_v[c] & (r != REF_SUPPLY);
      st_d.p1k_o[c]   = st_q.pd_v[2*c +: 2] == PD_1K;
      st_d.p100k_o[c] = st_q.pd_v[2*c +: 2] == PD_100K;
      st_d.popen_o[c] = st_q.pd_v[2*c +: 2] == PD_OPEN;
    end
    st_d.ref_o = st_q.ref_v;
    st_d.pd_o  = st_q.pd_v;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset models the power-on or brown-out event.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q          <= '0;
      st_q.por_flag <= STATUS_RESET[POR_BIT];
      st_q.boot     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata                 = st_q.rdata;
  assign rd_valid              = st_q.rd_valid;
  assign cmd_refused           = st_q.refused;
  assign nv_access_active      = st_q.nv_busy;
  assign reference_select_bits = st_q.ref_o;
  assign power_down_bits       = st_q.pd_o;
  assign gain_eff              = st_q.gain_o;
  assign ref_buffer_on         = st_q.buf_o;
  assign bandgap_on            = st_q.bg_o;
  assign ref_pin_driven        = st_q.drv_o;
  assign pd_1k                 = st_q.p1k_o;
  assign pd_100k               = st_q.p100k_o;
  assign pd_open               = st_q.popen_o;
  assign dac_value             = st_q.val;

  ////////////////////////////////////////////////////////////////////////////
  // Checks beside the logic.
  por_read_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd_en && !st_q.boot && addr == ADDR_GAIN_ST && !st_q.nv_busy)
      |=> (rdata[POR_BIT] == $past(st_q.por_flag)) ##1 !st_q.por_flag)
    else $error("status read did not report and clear power flag");
  gain_force_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.ref_v[1:0] == REF_SUPPLY) |=> !gain_eff[0])
    else $error("gain not forced to unity on supply reference");
  bg_on_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.ref_v[1:0] == REF_BANDGAP) |=> bandgap_on && ref_pin_driven[0])
    else $error("band gap not on for code 01");
  pd_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_en && !st_q.boot && addr == ADDR_PD_V)
      |=> st_q.pd_v == $past(wdata[FW-1:0]))
    else $error("power-down write lost");
  ref_lock_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_en && st_q.lock_nv[LOCK_CFG_BIT] && !st_q.boot)
      |=> $stable(st_q.ref_v[1:0]))
    else $error("locked reference changed");
  nv_hv_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_en && addr == ADDR_REF_NV && !hv_level && !st_q.boot)
      |=> cmd_refused && $stable(st_q.ref_nv))
    else $error("nonvolatile write without high voltage");
  nv_busy_len_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st_q.nv_busy) && st_q.nv_cnt == 5'(NV_LOAD_CYC) |-> st_q.nv_busy[*4])
    else $error("power-up load too short");
  pd_decode_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.pd_v[1:0] == PD_OPEN) |=> pd_open[0] && !pd_1k[0] && !pd_100k[0])
    else $error("power-down decode wrong");
  unimpl_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd_en && addr == ADDR_REF_V && !st_q.boot) |=> rdata[15:FW] == '0)
    else $error("unimplemented bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Decode, lock, status and power-up load checks.
  buf_ext_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.ref_v[1:0] == REF_EXT_BUF)
      |=> ref_buffer_on[0] && !ref_pin_driven[0])
    else $error("buffer off for buffered external reference");
  unbuf_ext_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.ref_v[1:0] == REF_EXT_UNBUF) |=> !ref_buffer_on[0])
    else $error("buffer on for unbuffered external reference");
  gain_double_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.gain_v[0] && st_q.ref_v[1:0] != REF_SUPPLY) |=> gain_eff[0])
    else $error("double gain not applied");
  nva_status_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd_en && !st_q.boot && addr == ADDR_GAIN_ST)
      |=> rdata[NVA_BIT] == $past(nv_access_active))
    else $error("access bit does not follow the busy state");
  nv_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
    ((wr_en || rd_en) && !st_q.boot && addr >= ADDR_NV_DAC0 && st_q.nv_busy)
      |=> cmd_refused)
    else $error("nonvolatile access accepted while busy");
  nva_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (!HAS_NV && rd_en && !st_q.boot) |=> !rdata[NVA_BIT])
    else $error("access bit set on a volatile-only build");
  val_lock_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_en && !st_q.boot && addr == ADDR_DAC1 && st_q.lock_nv[FW-1])
      |=> $stable(st_q.val[CHANNELS*VAL_W-1 -: VAL_W]))
    else $error("locked output value changed");
  boot_load_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.boot && HAS_NV) |=> st_q.ref_v == $past(nv_ref_init[FW-1:0]))
    else $error("reference bits not loaded at power-up");
endmodule // dcsr_regs

// ### hdl/dcsr_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages.
`timescale 1ns/100ps
module dcsr_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } dcsr_sync_s;
  dcsr_sync_s st_q;
  dcsr_sync_s st_d;

  // Shift the pin in; accept a change once stages two and three agree.
  always_comb begin
    st_d     = st_q;
    st_d.s1  = pin;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // Registers with synchronous reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
endmodule // dcsr_sync
